// *** src/uie_regs.sv ***
`default_nettype none
module uie_regs #(
  parameter int            DIV_W   = 16,
  parameter logic [4:0]    RX_TOP  = 5'h0E
) (
  // Clock and reset
  input  wire  logic             clock,
  input  wire  logic             sys_rst,
  // Host register bus
  input  wire  logic [2:0]       bus_addr,
  input  wire  logic             bus_rd,
  input  wire  logic             bus_wr,
  input  wire  logic [7:0]       bus_din,
  output logic       [7:0]       bus_dout,
  output logic                   bus_doe,
  // Receive FIFO status
  input  wire  logic [4:0]       rx_fill,
  input  wire  logic [7:0]       rx_data,
  input  wire  logic             rx_overrun,
  input  wire  logic [2:0]       rx_head_err,
  input  wire  logic             rx_any_err,
  output logic                   rx_pop,
  output logic                   rx_fifo_rst,
  // Transmit FIFO status
  input  wire  logic [4:0]       tx_fill,
  input  wire  logic             tx_hold_empty,
  input  wire  logic             tx_all_empty,
  output logic                   tx_push,
  output logic       [7:0]       tx_data,
  output logic                   tx_fifo_rst,
  // Modem and flow control
  input  wire  logic [7:0]       msr_value,
  input  wire  logic             msr_delta,
  output logic                   msr_read,
  input  wire  logic             cts_n,
  output logic                   rts_n,
  output logic                   dtr_n,
  input  wire  logic             xoff_detect,
  input  wire  logic             xon_detect,
  // Configuration out
  output logic       [7:0]       line_ctrl,
  output logic       [7:0]       modem_ctrl,
  output logic                   fifo_en,
  output logic       [4:0]       rx_trig_level,
  output logic       [4:0]       tx_trig_level,
  output logic                   auto_cts_en,
  output logic                   auto_rts_en,
  output logic                   special_char_sel,
  output logic       [3:0]       sw_flow_mode,
  output logic       [7:0]       resume_char_first,
  output logic       [7:0]       resume_char_second,
  output logic       [7:0]       pause_char_first,
  output logic       [7:0]       pause_char_second,
  output logic                   sleep_en,
  output logic                   poll_mode,
  output logic                   baud_tick,
  output logic                   irq
);

  typedef struct packed {
    logic [7:0]       interrupt_mask;
    logic [7:0]       line_control_reg;
    logic             fen;
    logic [1:0]       rxt;
    logic [1:0]       txt;
    logic [7:0]       modem_control_reg;
    logic [7:0]       enhanced_feature_control;
    logic [7:0]       dll;
    logic [7:0]       divisor_high;
    logic [7:0]       spr;
    logic [7:0]       res1;
    logic [7:0]       res2;
    logic [7:0]       pau1;
    logic [7:0]       pau2;
    logic             ovr;
    logic             txp;
    logic             txc;
    logic             xop;
    logic             flp;
    logic             cts_q;
    logic             rts_q;
    logic [DIV_W-1:0] bcnt;
    logic             tick;
    logic [7:0]       rdat;
    logic             roe;
    logic             pop;
    logic             push;
    logic [7:0]       tdat;
    logic             rrst;
    logic             trst;
    logic             mrd;
  } uie_state_t;

  uie_state_t q;
  uie_state_t next_q;

  function automatic logic [4:0] uie_lvl(input logic [1:0] s,
                                         input logic [4:0] top);
    case (s)
      2'h0:    uie_lvl = uie_pkg::TRIG_1;
      2'h1:    uie_lvl = uie_pkg::TRIG_4;
      2'h2:    uie_lvl = uie_pkg::TRIG_8;
      default: uie_lvl = top;
    endcase
  endfunction

  logic             key;
  logic             dsel;
  logic             enh;
  logic [7:0]       ier_eff;
  logic [7:0]       mcr_eff;
  logic [4:0]       rx_lvl;
  logic [4:0]       tx_lvl;
  logic [7:0]       line_status_reg;
  logic             lsr_int;
  logic             rx_int;
  logic             tx_int;
  logic             ms_int;
  logic             xo_int;
  logic             fl_int;
  logic [5:0]       src;
  logic             tx_cond;
  logic             tx_set;
  logic             tx_clr;
  logic             isr_rd;
  logic             lsr_rd;
  logic             msr_rd;
  logic             flow_set;
  logic [DIV_W-1:0] divisor;

  always_comb
  begin
    key     = (q.line_control_reg == uie_pkg::LCR_KEY);
    dsel    = q.line_control_reg[uie_pkg::LCR_DIV_BIT];
    enh     = q.enhanced_feature_control[uie_pkg::EFR_ENH_BIT];
    ier_eff = {enh ? q.interrupt_mask[7:4] : 4'h0, q.interrupt_mask[3:0]};
    mcr_eff = {enh ? q.modem_control_reg[7:5] : 3'h0, q.modem_control_reg[4:3],
               enh & q.modem_control_reg[2], q.modem_control_reg[1:0]};
    rx_lvl  = uie_lvl(q.rxt, RX_TOP);
    tx_lvl  = enh ? uie_lvl(q.txt, uie_pkg::TRIG_14) : uie_pkg::TRIG_1;
    // Line status
    line_status_reg = {rx_any_err, tx_all_empty, tx_hold_empty, rx_head_err,
           q.ovr, (rx_fill != 5'h00)};
    lsr_int = q.interrupt_mask[2] & (q.ovr | (|rx_head_err));
    rx_int  = q.interrupt_mask[0] & (q.fen ? (rx_fill >= rx_lvl)
                                : (rx_fill != 5'h00));
    tx_int  = q.interrupt_mask[1] & q.txp;
    ms_int  = q.interrupt_mask[3] & msr_delta;
    xo_int  = ier_eff[5] & q.xop;
    fl_int  = enh & q.flp;
    // Priority of sources
    if (lsr_int)
      src = uie_pkg::SRC_LINE;
    else if (rx_int)
      src = uie_pkg::SRC_RX;
    else if (tx_int)
      src = uie_pkg::SRC_TX;
    else if (ms_int)
      src = uie_pkg::SRC_MS;
    else if (xo_int)
      src = uie_pkg::SRC_XOFF;
    else if (fl_int)
      src = uie_pkg::SRC_FLOW;
    else
      src = uie_pkg::SRC_NONE;
    // Access decode
    isr_rd = bus_rd & !key & !(dsel & (bus_addr == uie_pkg::A_DIVH)) &
             (bus_addr == uie_pkg::A_ISRC);
    lsr_rd = bus_rd & !key & (bus_addr == uie_pkg::A_LSTAT);
    msr_rd = bus_rd & !key & (bus_addr == uie_pkg::A_MSTAT);
    // Transmit-ready event
    tx_cond = q.fen ? (tx_fill < tx_lvl) : tx_hold_empty;
    tx_set  = (tx_cond & !q.txc) |
              (tx_cond & bus_wr & !dsel & !key &
               (bus_addr == uie_pkg::A_IMASK) & bus_din[1] & !q.interrupt_mask[1]);
    tx_clr  = (isr_rd & (src == uie_pkg::SRC_TX)) |
              (bus_wr & !dsel & (bus_addr == uie_pkg::A_DATA));
    flow_set = enh & ((q.interrupt_mask[7] & cts_n & !q.cts_q) |
                      (q.interrupt_mask[6] & rts_n & !q.rts_q));
    divisor = {q.divisor_high, q.dll};

    next_q      = q;
    next_q.pop  = 1'b0;
    next_q.push = 1'b0;
    next_q.rrst = 1'b0;
    next_q.trst = 1'b0;
    next_q.mrd  = 1'b0;
    next_q.roe  = bus_rd;
    next_q.txc  = tx_cond;
    next_q.cts_q = cts_n;
    next_q.rts_q = rts_n;
    // Set wins over clear
    next_q.txp = tx_set | (q.txp & !tx_clr);
    next_q.ovr = rx_overrun | (q.ovr & !lsr_rd);
    next_q.xop = (enh & xoff_detect) |
                 (q.xop & !(isr_rd | xon_detect));
    next_q.flp = flow_set | (q.flp & !msr_rd);

    // Baud generator
    if (divisor == '0)
    begin
      next_q.bcnt = '0;
      next_q.tick = 1'b0;
    end
    else if (q.bcnt >= divisor - 1'b1)
    begin
      next_q.bcnt = '0;
      next_q.tick = 1'b1;
    end
    else
    begin
      next_q.bcnt = q.bcnt + 1'b1;
      next_q.tick = 1'b0;
    end

    // Writes
    if (bus_wr)
    begin
      if (key && bus_addr == uie_pkg::A_EFR)
        next_q.enhanced_feature_control = bus_din;
      else if (key && bus_addr == uie_pkg::A_RES1)
        next_q.res1 = bus_din;
      else if (key && bus_addr == uie_pkg::A_RES2)
        next_q.res2 = bus_din;
      else if (key && bus_addr == uie_pkg::A_PAU1)
        next_q.pau1 = bus_din;
      else if (key && bus_addr == uie_pkg::A_PAU2)
        next_q.pau2 = bus_din;
      else if (dsel && bus_addr == uie_pkg::A_DIVL)
        next_q.dll = bus_din;
      else if (dsel && bus_addr == uie_pkg::A_DIVH)
        next_q.divisor_high = bus_din;
      else
        unique case (bus_addr)
          uie_pkg::A_DATA:
          begin
            next_q.push = 1'b1;
            next_q.tdat = bus_din;
          end
          uie_pkg::A_IMASK:
            next_q.interrupt_mask = {enh ? bus_din[7:4] : q.interrupt_mask[7:4],
                          bus_din[3:0]};
          uie_pkg::A_ISRC:
            if (bus_din[0])
            begin
              next_q.fen  = 1'b1;
              next_q.rxt  = bus_din[7:6];
              next_q.txt  = enh ? bus_din[5:4] : q.txt;
              next_q.rrst = bus_din[1];
              next_q.trst = bus_din[2];
            end
            else
              next_q.fen = 1'b0;
          uie_pkg::A_LCTL:
            next_q.line_control_reg = bus_din;
          uie_pkg::A_MCTL:
            next_q.modem_control_reg = {enh ? bus_din[7:5] : q.modem_control_reg[7:5],
                          bus_din[4:3],
                          enh ? bus_din[2] : q.modem_control_reg[2],
                          bus_din[1:0]};
          uie_pkg::A_SCR:
            next_q.spr = bus_din;
          default:
            next_q.spr = q.spr;
        endcase
    end

    // Reads
    if (bus_rd)
    begin
      if (key && bus_addr == uie_pkg::A_EFR)
        next_q.rdat = q.enhanced_feature_control;
      else if (key && bus_addr >= uie_pkg::A_RES1)
        next_q.rdat = 8'h00;
      else if (dsel && bus_addr == uie_pkg::A_DIVL)
        next_q.rdat = q.dll;
      else if (dsel && bus_addr == uie_pkg::A_DIVH)
        next_q.rdat = q.divisor_high;
      else
        unique case (bus_addr)
          uie_pkg::A_DATA:
          begin
            next_q.rdat = rx_data;
            next_q.pop  = 1'b1;
          end
          uie_pkg::A_IMASK:
            next_q.rdat = ier_eff;
          uie_pkg::A_ISRC:
            next_q.rdat = {q.fen, q.fen,
                           enh ? src[5:4] : 2'h0, src[3:0]};
          uie_pkg::A_LCTL:
            next_q.rdat = q.line_control_reg;
          uie_pkg::A_MCTL:
            next_q.rdat = mcr_eff;
          uie_pkg::A_LSTAT:
            next_q.rdat = line_status_reg;
          uie_pkg::A_MSTAT:
          begin
            next_q.rdat = msr_value;
            next_q.mrd  = 1'b1;
          end
          default:
            next_q.rdat = q.spr;
        endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      q      <= '0;
      q.interrupt_mask  <= uie_pkg::REG_RST;
      q.line_control_reg  <= uie_pkg::REG_RST;
      q.enhanced_feature_control  <= uie_pkg::REG_RST;
      q.modem_control_reg  <= uie_pkg::REG_RST;
    end
    else
      q <= next_q;
  end

  assign bus_dout           = q.rdat;
  assign bus_doe            = q.roe;
  assign rx_pop             = q.pop;
  assign rx_fifo_rst        = q.rrst;
  assign tx_push            = q.push;
  assign tx_data            = q.tdat;
  assign tx_fifo_rst        = q.trst;
  assign msr_read           = q.mrd;
  assign rts_n              = ~q.modem_control_reg[1];
  assign dtr_n              = ~q.modem_control_reg[0];
  assign line_ctrl          = q.line_control_reg;
  assign modem_ctrl         = mcr_eff;
  assign fifo_en            = q.fen;
  assign rx_trig_level      = rx_lvl;
  assign tx_trig_level      = tx_lvl;
  assign auto_cts_en        = q.enhanced_feature_control[7];
  assign auto_rts_en        = q.enhanced_feature_control[6];
  assign special_char_sel   = q.enhanced_feature_control[5];
  assign sw_flow_mode       = q.enhanced_feature_control[3:0];
  assign resume_char_first  = q.res1;
  assign resume_char_second = q.res2;
  assign pause_char_first   = q.pau1;
  assign pause_char_second  = q.pau2;
  assign sleep_en           = ier_eff[4];
  assign poll_mode          = q.fen & (q.interrupt_mask[3:0] == 4'h0);
  assign baud_tick          = q.tick;
  assign irq                = (src != uie_pkg::SRC_NONE);

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_mask_tx_on;
    bus_wr && !dsel && !key && bus_addr == uie_pkg::A_IMASK &&
    bus_din[1] && !q.interrupt_mask[1] && tx_cond;
  endsequence

  sequence s_no_clear;
    !lsr_rd;
  endsequence

  AST_ENH_GATE: assert property (!enh |-> !sleep_en &&
    ier_eff[7:4] == 4'h0)
    else $error("extended mask bits live without enhanced mode");

  AST_BAUD_RELOAD: assert property (baud_tick |->
    $past(q.bcnt) == $past(divisor) - 1'b1)
    else $error("baud tick at wrong count");

  AST_DIV_LOCK: assert property (bus_wr && !dsel &&
    bus_addr == uie_pkg::A_DIVL |=> $stable(q.dll))
    else $error("divisor written while locked");

  AST_RX_TRIG: assert property (q.fen && q.interrupt_mask[0] && !lsr_int &&
    rx_fill >= rx_lvl |-> irq && src == uie_pkg::SRC_RX)
    else $error("receive trigger not reported");

  AST_LSR_READY: assert property (lsr_rd |=>
    bus_doe && bus_dout[0] == ($past(rx_fill) != 5'h00))
    else $error("data ready bit wrong");

  AST_OVERRUN: assert property (rx_overrun ##1 s_no_clear
    |=> q.ovr)
    else $error("overrun flag not held");

  AST_TX_NOW: assert property (s_mask_tx_on |=> q.txp && irq)
    else $error("transmit-ready not raised on enable");

  AST_TX_CLEAR: assert property (bus_wr && !dsel &&
    bus_addr == uie_pkg::A_DATA && !tx_set |=> !q.txp)
    else $error("transmit-ready not cleared by holding write");

  AST_CTS_EDGE: assert property (enh && q.interrupt_mask[7] &&
    $rose(cts_n) |=> q.flp)
    else $error("clear-to-send edge missed");

  AST_POLLED: assert property (poll_mode && !ier_eff[5] &&
    !fl_int |-> !irq)
    else $error("interrupt in polled mode");

endmodule
`default_nettype wire

// *** src/uie_pkg.sv ***
// What this block does
// - Extended fields ignored unless enhanced bit set
// - Baud generator is 16-bit divisor counter
// - Divisor reachable only with divisor-enable bit
// - Receive interrupt follows FIFO trigger level
// - Source register shows FIFO enable, clears
// - Data-ready set on push, clear empty
// - FIFO on, mask 0-3 clear: polled mode
// - Status bit 1 flags receive overrun
// - Status bits 2-4 give head error
// - Status bits 5,6 show transmit emptiness
// - Status bit 7: any FIFO error
// - Mask bit 0 enables receive interrupt
// - Mask bit 1 enables transmit-ready interrupt
// - Enable while empty raises transmit-ready at once
// - Mask bit 2: line-status interrupt
// - Overrun flagged at once, others at head
// - Mask bit 3: modem status interrupt
// - Mask bit 4: sleep, enhanced only
// - Mask bit 5: pause-char interrupt, enhanced
// - Mask bit 6: request-to-send rising interrupt
// - Mask bit 7: clear-to-send rising interrupt
// - Source read or holding write clears
`default_nettype none
package uie_pkg;
  // Primary map
  localparam logic [2:0] A_DATA  = 3'h0;
  localparam logic [2:0] A_IMASK = 3'h1;
  localparam logic [2:0] A_ISRC  = 3'h2;
  localparam logic [2:0] A_LCTL  = 3'h3;
  localparam logic [2:0] A_MCTL  = 3'h4;
  localparam logic [2:0] A_LSTAT = 3'h5;
  localparam logic [2:0] A_MSTAT = 3'h6;
  localparam logic [2:0] A_SCR   = 3'h7;
  // Divisor and enhanced maps
  localparam logic [2:0] A_DIVL  = 3'h0;
  localparam logic [2:0] A_DIVH  = 3'h1;
  localparam logic [2:0] A_EFR   = 3'h2;
  localparam logic [2:0] A_RES1  = 3'h4;
  localparam logic [2:0] A_RES2  = 3'h5;
  localparam logic [2:0] A_PAU1  = 3'h6;
  localparam logic [2:0] A_PAU2  = 3'h7;
  localparam logic [7:0] LCR_KEY = 8'hBF;
  localparam int LCR_DIV_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam logic [7:0] REG_RST = 8'h00;
  // Source codes
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_RX   = 6'h04;
  localparam logic [5:0] SRC_TX   = 6'h02;
  localparam logic [5:0] SRC_MS   = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  // Trigger levels
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
endpackage
`default_nettype wire

// *** verification/uie_host.sv ***
`default_nettype none
module uie_host (
  // Clock
  input  wire logic       clock,
  // Register bus
  output logic      [2:0] bus_addr,
  output logic            bus_rd,
  output logic            bus_wr,
  output logic      [7:0] bus_din,
  input  wire logic [7:0] bus_dout,
  input  wire logic       bus_doe
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  initial
  begin
    bus_addr = 3'h0;
    bus_rd   = 1'b0;
    bus_wr   = 1'b0;
    bus_din  = 8'h00;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge clock);
    #1;
    bus_addr = a;
    bus_din  = d;
    bus_wr   = 1'b1;
    @(posedge clock);
    #1;
    bus_wr   = 1'b0;
    // Released lines show the inverse
    bus_addr = ~a;
    bus_din  = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clock);
    #1;
    bus_addr = a;
    bus_rd   = 1'b1;
    @(posedge clock);
    #1;
    bus_rd   = 1'b0;
    bus_addr = ~a;
    while (bus_doe !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    d = bus_dout;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, sys_rst, bus_rd, bus_wr, bus_doe, irq;
  logic [2:0]  bus_addr, rx_head_err;
  logic [7:0]  bus_din, bus_dout, rx_data, msr_value, tx_data, d;
  logic [7:0]  rc1, rc2, pc1, pc2;
  logic [4:0]  rx_fill, tx_fill, rx_trig_level;
  logic [3:0]  sw_flow_mode;
  logic        rx_overrun, rx_any_err, tx_hold_empty, tx_all_empty;
  logic        tx_push, msr_delta, cts_n, rts_n, xoff_detect, fifo_en;
  logic        auto_cts_en, auto_rts_en, special_char_sel, sleep_en;
  logic        poll_mode, baud_tick, xon_detect;
  logic        rx_pop, rx_fifo_rst, tx_fifo_rst, msr_read, dtr_n;
  logic [7:0]  line_ctrl, modem_ctrl;
  logic [4:0]  tx_trig_level;
  logic [31:0] lfsr_q = 32'h136102FC;
  int          errors = 0;
  int          checks_done = 0;
  int          n;
  bit          m_ovr = 1'b0;
  bit          m_fen = 1'b0;
  logic [7:0]  q[$];

  uie_host uie_host_inst (.clock(clock), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_din(bus_din),
    .bus_dout(bus_dout), .bus_doe(bus_doe));
  uie_regs uie_regs_inst (.clock(clock), .sys_rst(sys_rst),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_din(bus_din), .bus_dout(bus_dout), .bus_doe(bus_doe),
    .rx_fill(rx_fill), .rx_data(rx_data), .rx_overrun(rx_overrun),
    .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
    .rx_pop(rx_pop), .rx_fifo_rst(rx_fifo_rst), .tx_fill(tx_fill),
    .tx_hold_empty(tx_hold_empty),
    .tx_all_empty(tx_all_empty), .tx_push(tx_push), .tx_data(tx_data),
    .tx_fifo_rst(tx_fifo_rst), .msr_value(msr_value),
    .msr_delta(msr_delta),
    .msr_read(msr_read), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n),
    .xoff_detect(xoff_detect), .xon_detect(xon_detect),
    .line_ctrl(line_ctrl), .modem_ctrl(modem_ctrl), .fifo_en(fifo_en),
    .rx_trig_level(rx_trig_level), .tx_trig_level(tx_trig_level),
    .auto_cts_en(auto_cts_en), .auto_rts_en(auto_rts_en),
    .special_char_sel(special_char_sel), .sw_flow_mode(sw_flow_mode),
    .resume_char_first(rc1), .resume_char_second(rc2),
    .pause_char_first(pc1), .pause_char_second(pc2),
    .sleep_en(sleep_en), .poll_mode(poll_mode),
    .baud_tick(baud_tick), .irq(irq));

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] lsr_exp();
    return {rx_any_err, tx_all_empty, tx_hold_empty, rx_head_err,
            m_ovr, rx_fill != 5'h00};
  endfunction
  function automatic logic [7:0] src(input logic [5:0] c);
    return {m_fen, m_fen, c};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] v);
    uie_host_inst.wr(a, v);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    uie_host_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    #200000;
    errors++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {rx_fill, tx_fill, rx_head_err, rx_overrun, rx_any_err} = '0;
    {rx_data, msr_value, msr_delta, cts_n, xoff_detect, xon_detect} = '0;
    tx_hold_empty = 1'b1;
    tx_all_empty = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk(irq, 1'b0);
    rc(3'h1, 8'h00);
    w(3'h1, 8'hF8);
    rc(3'h1, 8'h08);
    chk(sleep_en, 1'b0);
    w(3'h2, 8'h01);
    m_fen = 1'b1;
    w(3'h1, 8'h00);
    chk({fifo_en, poll_mode}, 2'b11);
    w(3'h3, uie_pkg::LCR_KEY);
    w(3'h2, 8'hD5);
    rc(3'h2, 8'hD5);
    chk({auto_cts_en, auto_rts_en, special_char_sel, sw_flow_mode},
        7'h65);
    uie_host_inst.gap = 1;
    for (int i = 4; i < 8; i++)
    begin
      lfsr_q = lfsr(lfsr_q);
      q.push_back(lfsr_q[7:0]);
      w(i[2:0], lfsr_q[7:0]);
    end
    chk({rc1, rc2, pc1, pc2}, {q[0], q[1], q[2], q[3]});
    rc(3'h4, 8'h00);
    uie_host_inst.gap = 0;
    w(3'h3, 8'h00);
    w(3'h1, 8'hF0);
    rc(3'h1, 8'hF0);
    chk({sleep_en, poll_mode, irq}, 3'b110);
    cts_n = 1'b1;
    tick(2);
    chk(irq, 1'b1);
    rc(3'h2, src(uie_pkg::SRC_FLOW));
    rc(3'h6, msr_value);
    chk(msr_read, 1'b1);
    w(3'h4, 8'h02);
    chk(rts_n, 1'b0);
    chk({dtr_n, modem_ctrl}, 9'h102);
    tick(2);
    chk(irq, 1'b0);
    w(3'h4, 8'h00);
    tick(2);
    chk(irq, 1'b1);
    rc(3'h6, msr_value);
    xoff_detect = 1'b1;
    tick(1);
    xoff_detect = 1'b0;
    tick(1);
    chk(irq, 1'b1);
    rc(3'h2, src(uie_pkg::SRC_XOFF));
    tick(2);
    chk(irq, 1'b0);
    xoff_detect = 1'b1;
    tick(1);
    xoff_detect = 1'b0;
    chk(irq, 1'b1);
    xon_detect = 1'b1;
    tick(1);
    xon_detect = 1'b0;
    chk(irq, 1'b0);
    // Divisor map
    w(3'h1, 8'h08);
    w(3'h3, 8'h80);
    chk(line_ctrl, 8'h80);
    w(3'h0, 8'h03);
    w(3'h1, 8'h00);
    rc(3'h0, 8'h03);
    rc(3'h1, 8'h00);
    n = 0;
    while (baud_tick !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (baud_tick !== 1'b1 && n < 20);
    chk(n, 3);
    w(3'h3, 8'h03);
    rc(3'h1, 8'h08);
    // Transmit ready
    w(3'h1, 8'h02);
    tick(2);
    chk(irq, 1'b1);
    rc(3'h2, src(uie_pkg::SRC_TX));
    tick(2);
    chk(irq, 1'b0);
    tx_fill = 5'h01;
    tick(2);
    tx_fill = 5'h00;
    tick(2);
    chk(irq, 1'b1);
    lfsr_q = lfsr(lfsr_q);
    w(3'h0, lfsr_q[7:0]);
    chk({tx_push, tx_data}, {1'b1, lfsr_q[7:0]});
    tick(2);
    chk(irq, 1'b0);
    // Receive trigger
    w(3'h2, 8'h47);
    chk({rx_fifo_rst, tx_fifo_rst, tx_trig_level},
        {2'b11, uie_pkg::TRIG_1});
    chk(rx_trig_level, uie_pkg::TRIG_4);
    w(3'h1, 8'h01);
    rx_fill = 5'h03;
    tick(2);
    chk(irq, 1'b0);
    rx_fill = 5'h04;
    tick(2);
    chk(irq, 1'b1);
    rc(3'h2, src(uie_pkg::SRC_RX));
    rx_fill = 5'h03;
    tick(2);
    chk(irq, 1'b0);
    rc(3'h2, src(uie_pkg::SRC_NONE));
    // Line status
    w(3'h1, 8'h04);
    for (int i = 0; i < 6; i++)
    begin
      lfsr_q = lfsr(lfsr_q);
      {rx_any_err, rx_head_err, rx_fill} = {lfsr_q[8:5], 1'b0, lfsr_q[3:0]};
      {tx_hold_empty, tx_all_empty} = {lfsr_q[9], lfsr_q[9] & lfsr_q[10]};
      rx_data = lfsr_q[23:16];
      rx_overrun = i[0];
      m_ovr = m_ovr | i[0];
      tick(1);
      rx_overrun = 1'b0;
      tick(1);
      chk(irq, m_ovr | (|rx_head_err));
      rc(3'h5, lsr_exp());
      m_ovr = 1'b0;
      tick(1);
      rc(3'h5, lsr_exp());
      chk(irq, |rx_head_err);
    end
    rc(3'h0, rx_data);
    chk(rx_pop, 1'b1);
    // Modem status
    w(3'h1, 8'h08);
    msr_delta = 1'b1;
    tick(2);
    chk(irq, 1'b1);
    w(3'h1, 8'h00);
    tick(2);
    chk(irq, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
